// >>> rtl/ovfc_limit_check.sv
// Validity check for a written overvoltage warning limit
// Assumes limits share one linear exponent
`timescale 1ns/100ps
`default_nettype none
module ovfc_limit_check (
  // Candidate and references
  input wire logic [15:0] candidate,
  input wire logic [15:0] vout_command,
  input wire logic [15:0] fault_limit,
  input wire logic [7:0] scale_loop,
  // Result
  output logic valid
);
  import ovfc_pkg::*;
  logic [23:0] scaled;
  always_comb begin
    scaled = candidate * scale_loop;
    valid = (candidate > vout_command) && (candidate < fault_limit) &&
            (scaled > OVFC_WARN_SCALED_MIN) &&
            ((candidate & ~OVFC_WARN_MASK) == 16'h0000);
  end
endmodule
`default_nettype wire

// >>> rtl/ovfc_pkg.sv
// Package for the output overvoltage fault control block
// Assumes a single 100 MHz clock domain
package ovfc_pkg;
  // Command codes of the two registers
  localparam logic [7:0] OVFC_CMD_RESPONSE = 8'h41;
  localparam logic [7:0] OVFC_CMD_WARN_LIMIT = 8'h42;
  // Response register layout
  localparam int OVFC_RSP_SELECT_BIT = 7;
  localparam int OVFC_RSP_ZERO_BIT = 6;
  localparam int OVFC_RSP_RETRY_HI = 5;
  localparam int OVFC_RSP_RETRY_LO = 3;
  localparam logic [7:0] OVFC_RESPONSE_RESET = 8'hBF;
  localparam logic [2:0] OVFC_FIXED_DELAY = 3'h7;
  localparam logic [2:0] OVFC_RETRY_LATCH = 3'h0;
  localparam logic [2:0] OVFC_RETRY_ENDLESS = 3'h7;
  // Warning limit layout
  localparam logic [15:0] OVFC_WARN_RESET = 16'h0267;
  localparam logic [15:0] OVFC_WARN_MASK = 16'h0FFF;
  localparam logic [4:0] OVFC_VOUT_EXPONENT = 5'h17;
  localparam logic [23:0] OVFC_WARN_SCALED_MIN = 24'h00010D;
  // Restart delay in soft-start rise intervals
  localparam logic [3:0] OVFC_RETRY_INTERVALS = 4'h7;
  // Rise time is an input count of microseconds
  localparam int OVFC_CLK_MHZ = 100;
  localparam int OVFC_US_CYCLES = OVFC_CLK_MHZ;
  localparam logic [6:0] OVFC_US_COUNT_MAX = 7'(OVFC_US_CYCLES - 1);
  // Retry state machine
  typedef enum logic [1:0] {
    OVFC_RUN, OVFC_DOWN, OVFC_WAIT, OVFC_LATCHED
  } ovfc_state_e;
endpackage

// >>> rtl/ovfc_retry_timer.sv
// Times seven soft-start rise intervals after an overvoltage shutdown
// Assumes rise time is given in whole microseconds
`timescale 1ns/100ps
`default_nettype none
module ovfc_retry_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic [15:0] soft_start_rise_time,
  // Result
  output logic done
);
  import ovfc_pkg::*;
  logic [6:0] us_reg, us_next;
  logic [15:0] rise_reg, rise_next;
  logic [3:0] ivl_reg, ivl_next;
  logic run_reg, run_next;
  logic us_tick;
  always_comb begin
    us_tick = run_reg && (us_reg == OVFC_US_COUNT_MAX);
    us_next = us_reg;
    rise_next = rise_reg;
    ivl_next = ivl_reg;
    run_next = run_reg;
    done = 1'b0;
    if (abort) begin
      run_next = 1'b0;
    end else if (start) begin
      run_next = 1'b1;
      us_next = '0;
      rise_next = '0;
      ivl_next = '0;
    end else if (run_reg) begin
      us_next = us_tick ? '0 : us_reg + 7'h01;
      if (us_tick) begin
        if (rise_reg + 16'h0001 >= soft_start_rise_time) begin
          rise_next = '0;
          ivl_next = ivl_reg + 4'h1;
          if (ivl_reg + 4'h1 == OVFC_RETRY_INTERVALS) begin
            run_next = 1'b0;
            done = 1'b1;
          end
        end else begin
          rise_next = rise_reg + 16'h0001;
        end
      end
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      us_reg <= '0;
      rise_reg <= '0;
      ivl_reg <= '0;
      run_reg <= 1'b0;
    end else begin
      us_reg <= us_next;
      rise_reg <= rise_next;
      ivl_reg <= ivl_next;
      run_reg <= run_next;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ovfc_top.sv
// Output overvoltage fault response and warning limit registers
// Assumes a decoded command port from the host transaction layer
`timescale 1ns/100ps
`default_nettype none
module ovfc_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Command port
  input wire logic wr_en,
  input wire logic [7:0] wr_cmd,
  input wire logic [15:0] wr_data,
  input wire logic [7:0] rd_cmd,
  output logic [15:0] rd_data,
  // Non-volatile storage
  input wire logic store_all,
  input wire logic restore_all,
  output logic nv_store_en,
  output logic nv_retry_bit,
  output logic nv_select_bit,
  input wire logic nv_retry_bit_in,
  input wire logic nv_select_bit_in,
  // Converter context
  input wire logic [15:0] vout_command,
  input wire logic [15:0] fault_limit,
  input wire logic [7:0] scale_loop,
  input wire logic [15:0] soft_start_rise_time,
  input wire logic output_on_cmd,
  input wire logic other_fault,
  // Comparator events
  input wire logic ov_fault_event,
  input wire logic ov_warn_event,
  // Status
  input wire logic clear_faults,
  input wire logic [3:0] alert_mask,
  output logic overvoltage_fault_flag,
  output logic overvoltage_warning_flag,
  output logic voltage_flag_word,
  output logic comm_error_flag,
  output logic invalid_data_flag,
  output logic ov_fault_byte_flag,
  output logic other_flag,
  output logic smbalert_n,
  // Output stage control
  output logic output_enable,
  output logic soft_start_req,
  output logic [15:0] warn_limit_out,
  output logic [4:0] vout_exponent
);
  import ovfc_pkg::*;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic select_reg, select_next;
  logic [2:0] retry_field_reg, retry_field_next;
  logic [15:0] warn_reg, warn_next;
  logic ovf_reg, ovf_next;
  logic ovw_reg, ovw_next;
  logic cml_reg, cml_next;
  logic ivd_reg, ivd_next;
  logic warn_init_reg, warn_init_next;
  logic [15:0] rd_reg, rd_next;
  ovfc_state_e state_reg, state_next;
  logic warn_ok, timer_start, timer_abort, timer_done;
  logic [15:0] warn_default;
  logic [7:0] response_value;
  logic [2:0] wr_retry;
  logic rsp_write, warn_write, rsp_accept, warn_accept, bad_write;

  ovfc_limit_check u_check (
    .candidate(wr_data),
    .vout_command(vout_command),
    .fault_limit(fault_limit),
    .scale_loop(scale_loop),
    .valid(warn_ok)
  );

  ovfc_retry_timer u_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(timer_start),
    .abort(timer_abort),
    .soft_start_rise_time(soft_start_rise_time),
    .done(timer_done)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic retry_latches(input logic [2:0] r);
    return r == OVFC_RETRY_LATCH;
  endfunction

  // Retry code must be all zeros or all ones
  function automatic logic retry_legal(input logic [2:0] r);
    return retry_latches(r) || (r == OVFC_RETRY_ENDLESS);
  endfunction

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  always_comb begin
    wr_retry = wr_data[OVFC_RSP_RETRY_HI:OVFC_RSP_RETRY_LO];
    rsp_write = wr_en && (wr_cmd == OVFC_CMD_RESPONSE);
    warn_write = wr_en && (wr_cmd == OVFC_CMD_WARN_LIMIT);
    rsp_accept = rsp_write && retry_legal(wr_retry);
    warn_accept = warn_write && warn_ok;
    bad_write = (rsp_write && !rsp_accept) ||
                (warn_write && !warn_accept);
    warn_default = fault_limit - {4'h0, fault_limit[15:4]};
    // Fallback keeps the warning above the commanded voltage
    if (warn_default <= vout_command) begin
      warn_default = fault_limit - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_comb begin
    select_next = select_reg;
    retry_field_next = retry_field_reg;
    warn_next = warn_reg;
    warn_init_next = 1'b1;
    // Default limit follows the fault limit seen after reset
    if (!warn_init_reg) begin
      warn_next = warn_default & OVFC_WARN_MASK;
    end
    if (restore_all) begin
      select_next = nv_select_bit_in;
      retry_field_next = {3{nv_retry_bit_in}};
    end
    // A rejected write keeps the old setting
    if (rsp_accept) begin
      select_next = wr_data[OVFC_RSP_SELECT_BIT];
      retry_field_next = wr_retry;
    end
    if (warn_accept) begin
      warn_next = wr_data & OVFC_WARN_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      select_reg <= OVFC_RESPONSE_RESET[OVFC_RSP_SELECT_BIT];
      retry_field_reg <=
        OVFC_RESPONSE_RESET[OVFC_RSP_RETRY_HI:OVFC_RSP_RETRY_LO];
      warn_reg <= OVFC_WARN_RESET;
      warn_init_reg <= 1'b0;
    end else begin
      select_reg <= select_next;
      retry_field_reg <= retry_field_next;
      warn_reg <= warn_next;
      warn_init_reg <= warn_init_next;
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  always_comb begin
    ovf_next = ovf_reg;
    ovw_next = ovw_reg;
    cml_next = cml_reg;
    ivd_next = ivd_reg;
    if (clear_faults) begin
      ovf_next = 1'b0;
      ovw_next = 1'b0;
      cml_next = 1'b0;
      ivd_next = 1'b0;
    end
    // Events win over a clear in the same cycle
    if (bad_write) begin
      cml_next = 1'b1;
      ivd_next = 1'b1;
    end
    if (ov_fault_event) begin
      ovf_next = 1'b1;
    end
    if (ov_warn_event) begin
      ovw_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ovf_reg <= 1'b0;
      ovw_reg <= 1'b0;
      cml_reg <= 1'b0;
      ivd_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_next;
      ovw_reg <= ovw_next;
      cml_reg <= cml_next;
      ivd_reg <= ivd_next;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    response_value = {select_reg, 1'b0, retry_field_reg,
                      OVFC_FIXED_DELAY};
    unique case (rd_cmd)
      OVFC_CMD_RESPONSE: rd_next = {8'h00, response_value};
      OVFC_CMD_WARN_LIMIT: rd_next = warn_reg;
      default: rd_next = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_reg <= 16'h0000;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // ---------------------------------------------------------------
  // Fault response sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    timer_start = 1'b0;
    timer_abort = !output_on_cmd || other_fault;
    unique case (state_reg)
      OVFC_RUN: begin
        if (ov_fault_event && select_reg) begin
          state_next = retry_latches(retry_field_reg) ?
                       OVFC_LATCHED : OVFC_DOWN;
        end
      end
      OVFC_DOWN: begin
        timer_start = 1'b1;
        state_next = OVFC_WAIT;
      end
      OVFC_WAIT: begin
        if (timer_abort) begin
          state_next = OVFC_LATCHED;
        end else if (timer_done) begin
          state_next = OVFC_RUN;
        end
      end
      OVFC_LATCHED: begin
        if (clear_faults || !output_on_cmd) begin
          state_next = OVFC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= OVFC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rd_data = rd_reg;
  assign nv_store_en = store_all;
  assign nv_select_bit = select_reg;
  assign nv_retry_bit = retry_field_reg[2];
  assign overvoltage_fault_flag = ovf_reg;
  assign ov_fault_byte_flag = ovf_reg;
  assign overvoltage_warning_flag = ovw_reg;
  assign other_flag = ovw_reg;
  assign voltage_flag_word = ovf_reg | ovw_reg;
  assign comm_error_flag = cml_reg;
  assign invalid_data_flag = ivd_reg;
  assign smbalert_n = !((ovf_reg & !alert_mask[0]) |
                        (ovw_reg & !alert_mask[1]) |
                        (cml_reg & !alert_mask[2]) |
                        (ivd_reg & !alert_mask[3]));
  assign output_enable = output_on_cmd && (state_reg == OVFC_RUN);
  assign soft_start_req = (state_reg == OVFC_WAIT) && timer_done;
  assign warn_limit_out = warn_reg;
  assign vout_exponent = OVFC_VOUT_EXPONENT;
endmodule
`default_nettype wire

// >>> sim/ovfc_host_model.sv
// Host model issuing decoded register writes and reads
// Assumes the block samples its command port at sys_clk rising edges
`timescale 1ns/100ps
`default_nettype none
module ovfc_host_model (
  // Clock
  input wire logic sys_clk,
  // Command port
  output var logic wr_en,
  output var logic [7:0] wr_cmd,
  output var logic [15:0] wr_data,
  output var logic [7:0] rd_cmd,
  input wire logic [15:0] rd_data
);
  initial begin
    {wr_en, wr_cmd, wr_data, rd_cmd} = 33'h0;
  end
  // One-cycle strobe; data inverted once released
  task automatic host_write(input logic [7:0] c, input logic [15:0] v);
    @(posedge sys_clk);
    #1;
    {wr_en, wr_cmd, wr_data} = {1'b1, c, v};
    @(posedge sys_clk);
    #1;
    {wr_en, wr_data} = {1'b0, ~v};
  endtask
  task automatic host_read(input logic [7:0] c, output logic [15:0] v);
    @(posedge sys_clk);
    #1;
    rd_cmd = c;
    @(posedge sys_clk);
    #1;
    v = rd_data;
    rd_cmd = ~c;
  endtask
endmodule
`default_nettype wire

// >>> sim/ovfc_properties.sv
// Port checker for the overvoltage fault control block
// Assumes binding to ovfc_top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module ovfc_properties
  import ovfc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Watched ports
  input wire logic wr_en,
  input wire logic [7:0] wr_cmd,
  input wire logic [15:0] wr_data,
  input wire logic [7:0] rd_cmd,
  input wire logic [15:0] rd_data,
  input wire logic ov_fault_event,
  input wire logic ov_warn_event,
  input wire logic clear_faults,
  input wire logic [3:0] alert_mask,
  input wire logic output_on_cmd,
  input wire logic overvoltage_fault_flag,
  input wire logic overvoltage_warning_flag,
  input wire logic voltage_flag_word,
  input wire logic comm_error_flag,
  input wire logic invalid_data_flag,
  input wire logic ov_fault_byte_flag,
  input wire logic other_flag,
  input wire logic smbalert_n,
  input wire logic output_enable,
  input wire logic soft_start_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_fault_flags: assert property (
    ov_fault_event && !alert_mask[0] |=> overvoltage_fault_flag &&
    ov_fault_byte_flag && voltage_flag_word && !smbalert_n)
    else $error("fault flags missing");
  a_warn_flags: assert property (
    ov_warn_event |=> overvoltage_warning_flag && other_flag &&
    voltage_flag_word) else $error("warning flags missing");
  a_bad_retry: assert property (
    wr_en && wr_cmd == OVFC_CMD_RESPONSE && wr_data[5:3] != 3'h0 &&
    wr_data[5:3] != 3'h7 |=> comm_error_flag && invalid_data_flag)
    else $error("bad retry not flagged");
  a_flag_latch: assert property (
    overvoltage_fault_flag && !clear_faults |=> overvoltage_fault_flag)
    else $error("fault flag dropped");
  a_alert_cause: assert property (
    !smbalert_n |-> overvoltage_fault_flag || overvoltage_warning_flag ||
    comm_error_flag || invalid_data_flag) else $error("alert without flag");
  a_rsp_fixed: assert property (
    $past(resetn) && $past(rd_cmd) == OVFC_CMD_RESPONSE |-> !rd_data[6] &&
    rd_data[15:8] == 8'h00 && rd_data[2:0] == 3'h7)
    else $error("response fixed bits wrong");
  a_warn_top: assert property (
    $past(resetn) && $past(rd_cmd) == OVFC_CMD_WARN_LIMIT |->
    rd_data[15:12] == 4'h0) else $error("warning top bits set");
  a_restart_on: assert property (
    soft_start_req && output_on_cmd && !ov_fault_event |=> output_enable)
    else $error("no restart after soft start");
  c_retry: cover property (soft_start_req);
  c_reject: cover property (wr_en ##1 invalid_data_flag);
  c_warn: cover property (ov_warn_event ##1 !smbalert_n);
endmodule
bind ovfc_top ovfc_properties ovfc_properties_inst (.*);
`default_nettype wire

// >>> sim/ovfc_tb_top.sv
// Self-checking bench for the overvoltage fault control block
// Assumes the host model and the bound checker compile with it
`timescale 1ns/100ps
`default_nettype none
module ovfc_tb_top;
  import ovfc_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn, wr_en, store_all, restore_all, nv_store_en, nv_retry_bit;
  logic nv_select_bit, nv_retry_bit_in, nv_select_bit_in, output_on_cmd;
  logic other_fault, ov_fault_event, ov_warn_event, clear_faults;
  logic overvoltage_fault_flag, overvoltage_warning_flag, voltage_flag_word;
  logic comm_error_flag, invalid_data_flag, ov_fault_byte_flag, other_flag;
  logic smbalert_n, output_enable, soft_start_req;
  logic [3:0] alert_mask, ff, wf;
  logic [4:0] vout_exponent;
  logic [7:0] wr_cmd, rd_cmd, scale_loop;
  logic [15:0] wr_data, rd_data, vout_command, fault_limit, warn_limit_out;
  logic [15:0] soft_start_rise_time, x, exp_w;
  logic [15:0] corner [7] = '{16'h010D, 16'h010E, 16'h0290, 16'h028F,
    16'h110E, 16'h00C8, 16'h00C9};
  integer seed = 32'hDCE73285;
  int failures = 0;
  int num_checks = 0;
  int n;
  assign ff = {overvoltage_fault_flag, ov_fault_byte_flag, voltage_flag_word,
    smbalert_n};
  assign wf = {overvoltage_warning_flag, other_flag, voltage_flag_word,
    smbalert_n};
  ovfc_top ovfc_top_inst (.*);
  ovfc_host_model ovfc_host_model_inst (.*);
  always #5 sys_clk = ~sys_clk;
  function automatic logic [15:0] dflt(input logic [15:0] f, v);
    return (f - (f >> 4) > v) ? f - (f >> 4) : f - 16'h0001;
  endfunction
  function automatic logic ok_warn(input logic [15:0] w);
    return w[15:12] == 4'h0 && w > vout_command && w < fault_limit &&
      24'(w) * 24'(scale_loop) > 24'h00010D;
  endfunction
  task automatic chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkf(input logic [3:0] got, exp);
    chk({12'h000, got}, {12'h000, exp});
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    ovfc_host_model_inst.host_write(c, v);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] v;
    ovfc_host_model_inst.host_read(c, v);
    chk(v, e);
  endtask
  // Pulse order: fault, warning, clear
  task automatic pulse(input logic [2:0] p);
    {ov_fault_event, ov_warn_event, clear_faults} = p;
    tick(1);
    {ov_fault_event, ov_warn_event, clear_faults} = 3'h0;
  endtask
  task automatic do_reset;
    resetn = 1'b0;
    tick(6);
    resetn = 1'b1;
    tick(2);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    {store_all, restore_all, nv_retry_bit_in, nv_select_bit_in} = 4'h0;
    {other_fault, ov_fault_event, ov_warn_event, clear_faults} = 4'h0;
    {output_on_cmd, alert_mask, scale_loop} = {1'b1, 4'h0, 8'h01};
    {vout_command, fault_limit} = {16'h01E6, 16'h0290};
    soft_start_rise_time = 16'h0001;
    do_reset;
    exp_w = dflt(fault_limit, vout_command);
    chk(warn_limit_out, exp_w);
    rd(OVFC_CMD_RESPONSE, 16'h00BF);
    rd(8'h40, 16'h0000);
    chk({11'h000, vout_exponent}, 16'h0017);
    for (int i = 1; i < 7; i++) begin
      wr(OVFC_CMD_RESPONSE, 16'(i * 8));
      chkf({comm_error_flag, invalid_data_flag, smbalert_n, 1'b0},
        4'hC);
      rd(OVFC_CMD_RESPONSE, 16'h00BF);
      pulse(3'h1);
    end
    for (int i = 0; i < 8; i++) begin
      x = 16'($random(seed));
      x[5:3] = {3{x[5]}};
      wr(OVFC_CMD_RESPONSE, x);
      rd(OVFC_CMD_RESPONSE, {8'h00, x[7], 1'b0, x[5:3], 3'h7});
    end
    wr(OVFC_CMD_RESPONSE, 16'h0080);
    tick(1);
    store_all = 1'b1;
    #1;
    chkf({nv_store_en, nv_select_bit, nv_retry_bit, 1'b0}, 4'hC);
    tick(1);
    {store_all, restore_all, nv_retry_bit_in} = 3'h3;
    tick(1);
    restore_all = 1'b0;
    rd(OVFC_CMD_RESPONSE, 16'h003F);
    pulse(3'h4);
    chkf(ff, 4'hE);
    chkf({3'h0, output_enable}, 4'h1);
    alert_mask = 4'h1;
    #1;
    chkf({3'h0, smbalert_n}, 4'h1);
    alert_mask = 4'h0;
    pulse(3'h1);
    wr(OVFC_CMD_RESPONSE, 16'h00B8);
    pulse(3'h4);
    chkf({3'h0, output_enable}, 4'h0);
    n = 0;
    while (soft_start_req !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    chkf({3'h0, n >= 695 && n <= 708}, 4'h1);
    tick(2);
    chkf({3'h0, output_enable}, 4'h1);
    pulse(3'h4);
    tick(100);
    output_on_cmd = 1'b0;
    n = 0;
    repeat (800) begin
      tick(1);
      n += int'(soft_start_req);
    end
    chk(16'(n), 16'h0000);
    output_on_cmd = 1'b1;
    pulse(3'h4);
    tick(50);
    other_fault = 1'b1;
    tick(2);
    other_fault = 1'b0;
    n = 0;
    repeat (800) begin
      tick(1);
      n += int'(soft_start_req);
    end
    chk(16'(n), 16'h0000);
    chkf({3'h0, output_enable}, 4'h0);
    pulse(3'h1);
    wr(OVFC_CMD_RESPONSE, 16'h0080);
    pulse(3'h4);
    tick(1000);
    chkf({3'h0, output_enable}, 4'h0);
    pulse(3'h1);
    chkf({3'h0, output_enable}, 4'h1);
    pulse(3'h2);
    tick(20);
    chkf(wf, 4'hE);
    pulse(3'h1);
    chkf(wf, 4'h1);
    vout_command = 16'h00C8;
    for (int i = 0; i < 40; i++) begin
      x = (i < 7) ? corner[i] : 16'($random(seed)) & 16'h13FF;
      scale_loop = (i < 7) ? 8'h01 : 8'({$random(seed)} % 4 + 1);
      wr(OVFC_CMD_WARN_LIMIT, x);
      chkf({3'h0, invalid_data_flag},
        {3'h0, !ok_warn(x)});
      exp_w = ok_warn(x) ? x : exp_w;
      rd(OVFC_CMD_WARN_LIMIT, exp_w);
      pulse(3'h1);
    end
    vout_command = 16'h0280;
    do_reset;
    chk(warn_limit_out, dflt(fault_limit, vout_command));
    end_sim;
  end
  initial begin
    #600000;
    failures++;
    end_sim;
  end
endmodule
`default_nettype wire
